// ### rtl/timer1_pkg.sv
package timer1_pkg;
	// register indices; byte address is four times the index
	localparam logic [5:0] IDX_CTRL1 = 6'h14;
	localparam logic [5:0] IDX_RELOAD_HI = 6'h15;
	localparam logic [5:0] IDX_RELOAD_LO = 6'h16;
	localparam logic [5:0] IDX_COUNT_HI = 6'h17;
	localparam logic [5:0] IDX_COUNT_LO = 6'h18;
	localparam logic [5:0] IDX_CTRL2 = 6'h19;
	localparam logic [5:0] IDX_START_STOP = 6'h1E;
	localparam logic [5:0] IDX_IRQ_STATUS = 6'h1F;
	localparam int ADR_LSB = 2;

	// control register fields
	localparam int CTL_STOP_RX = 7;
	localparam int CTL_MODE_HI = 5;
	localparam int CTL_MODE_LO = 4;
	localparam int CTL_AUTO_RESTART = 3;
	localparam int CTL_CLK_HI = 1;
	localparam int CTL_CLK_LO = 0;
	localparam logic [7:0] CTL_WRITABLE = 8'hBB;
	localparam logic [7:0] CTL_RESET = 8'h00;

	// start/stop register fields
	localparam int SS_RUNNING = 5;
	localparam int SS_ENABLE = 1;
	// status register field
	localparam int ST_IRQ = 0;

	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [15:0] COUNT_ZERO = 16'h0000;
	localparam logic [15:0] COUNT_ONE = 16'h0001;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

	// prescaler from 13.56 MHz ticks down to 211.875 kHz
	localparam int PRESCALE_DIV = 64;
	localparam logic [5:0] PRESCALE_LAST = 6'(PRESCALE_DIV - 1);
	localparam logic [5:0] PRESCALE_ZERO = 6'h00;
	localparam logic [5:0] PRESCALE_ONE = 6'h01;

	typedef enum logic [1:0] {
		START_NONE = 2'b00,
		START_TX_END = 2'b01,
		START_TRIM_NO_UF = 2'b10,
		START_TRIM_UF = 2'b11
	} start_mode_e;

	typedef enum logic [1:0] {
		CLK_RF = 2'b00,
		CLK_RF_DIV = 2'b01,
		CLK_TIMER0 = 2'b10,
		CLK_TIMER2 = 2'b11
	} clock_select_e;

	// both trimming codes share bit 1
	function automatic logic is_trim(input logic [1:0] mode);
		is_trim = (mode == START_TRIM_NO_UF) || (mode == START_TRIM_UF);
	endfunction : is_trim
endpackage : timer1_pkg

// ### rtl/timer1_evt_if.sv
`timescale 1ns/1ps
interface timer1_evt_if;
	logic tick;
	logic start_evt;
	logic stop_evt;

	modport tick_src (output tick);
	modport evt_src (output start_evt, output stop_evt);
	modport sink (input tick, input start_evt, input stop_evt);
endinterface : timer1_evt_if

// ### rtl/timer1_tick_sel.sv
`timescale 1ns/1ps
module timer1_tick_sel (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// tick sources
	input wire logic rf_tick_i,
	input wire logic t0_underflow_i,
	input wire logic t2_underflow_i,
	// selection
	input wire logic [1:0] clock_select_field,
	// decrement tick
	timer1_evt_if.tick_src evt
);
	logic [5:0] prescale;
	logic div_tick;

	// divide rf ticks by 64, free running so phase is independent of starts
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			prescale <= timer1_pkg::PRESCALE_ZERO;
		end else if (rf_tick_i) begin
			prescale <= (prescale == timer1_pkg::PRESCALE_LAST) ? timer1_pkg::PRESCALE_ZERO
				: prescale + timer1_pkg::PRESCALE_ONE;
		end
	end

	assign div_tick = rf_tick_i && (prescale == timer1_pkg::PRESCALE_LAST);

	// source mux
	always_comb begin
		unique case (timer1_pkg::clock_select_e'(clock_select_field))
			timer1_pkg::CLK_RF: evt.tick = rf_tick_i;
			timer1_pkg::CLK_RF_DIV: evt.tick = div_tick;
			timer1_pkg::CLK_TIMER0: evt.tick = t0_underflow_i;
			timer1_pkg::CLK_TIMER2: evt.tick = t2_underflow_i;
		endcase
	end
endmodule : timer1_tick_sel

// ### rtl/timer1_evt_gen.sv
`timescale 1ns/1ps
module timer1_evt_gen (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// frame and oscillator inputs
	input wire logic tx_end_i,
	input wire logic rx_first_bits_i,
	input wire logic low_freq_oscillator_i,
	// control
	input wire logic [1:0] start_mode_field,
	input wire logic stop_on_receive_bit,
	input wire logic running,
	// events
	timer1_evt_if.evt_src evt
);
	logic lfo_prev;
	logic lfo_rise;

	// previous oscillator level for edge detection
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lfo_prev <= 1'b0;
		end else begin
			lfo_prev <= low_freq_oscillator_i;
		end
	end

	assign lfo_rise = low_freq_oscillator_i && !lfo_prev;

	// start and stop events per mode
	always_comb begin
		evt.start_evt = 1'b0;
		evt.stop_evt = 1'b0;
		unique case (timer1_pkg::start_mode_e'(start_mode_field))
			timer1_pkg::START_NONE: evt.start_evt = 1'b0;
			timer1_pkg::START_TX_END: evt.start_evt = tx_end_i;
			timer1_pkg::START_TRIM_NO_UF, timer1_pkg::START_TRIM_UF: begin
				// one rising edge starts, the next one stops
				evt.start_evt = lfo_rise && !running;
				evt.stop_evt = lfo_rise && running;
			end
		endcase
		// receive stop has no meaning while trimming
		if (stop_on_receive_bit && rx_first_bits_i && !timer1_pkg::is_trim(start_mode_field)) begin
			evt.stop_evt = 1'b1;
		end
	end
endmodule : timer1_evt_gen

// ### rtl/timer1_countdown.sv
`timescale 1ns/1ps
module timer1_countdown (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// tick sources
	input wire logic rf_tick_i,
	input wire logic t0_underflow_i,
	input wire logic t2_underflow_i,
	// frame and oscillator inputs
	input wire logic tx_end_i,
	input wire logic rx_first_bits_i,
	input wire logic low_freq_oscillator_i,
	// timer outputs
	output logic underflow_o,
	output logic timer_one_irq_flag_o,
	output logic timer_one_running_status_o,
	output logic [7:0] timer_two_control_o
);
	timer1_evt_if evt ();

	// registers
	logic [7:0] timer_one_control;
	logic [7:0] timer_two_control;
	logic [7:0] reload_high_byte;
	logic [7:0] reload_low_byte;
	logic [15:0] count;
	logic running;
	logic timer_one_irq_flag;

	// decoded bus access
	logic [5:0] reg_index;
	logic bus_req;
	logic wr_lane0;
	logic wr_ctrl1;
	logic wr_ctrl2;
	logic wr_reload_hi;
	logic wr_reload_lo;
	logic wr_start_stop;
	logic wr_irq_status;
	logic irq_clear;

	// control fields
	logic stop_on_receive_bit;
	logic [1:0] start_mode_field;
	logic auto_restart_bit;
	logic [1:0] clock_select_field;
	logic [15:0] reload_value;

	// counter events
	logic cmd_change;
	logic cmd_run;
	logic at_zero;
	logic count_step;
	logic underflow_now;
	logic trim_hold;
	logic next_running;
	logic [15:0] next_count;
	logic [31:0] next_rdata;

	assign stop_on_receive_bit = timer_one_control[timer1_pkg::CTL_STOP_RX];
	assign start_mode_field = timer_one_control[timer1_pkg::CTL_MODE_HI:timer1_pkg::CTL_MODE_LO];
	assign auto_restart_bit = timer_one_control[timer1_pkg::CTL_AUTO_RESTART];
	assign clock_select_field = timer_one_control[timer1_pkg::CTL_CLK_HI:timer1_pkg::CTL_CLK_LO];
	assign reload_value = {reload_high_byte, reload_low_byte};

	// tick source selection and prescaler
	timer1_tick_sel u_tick_sel (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.rf_tick_i(rf_tick_i),
		.t0_underflow_i(t0_underflow_i),
		.t2_underflow_i(t2_underflow_i),
		.clock_select_field(clock_select_field),
		.evt(evt.tick_src)
	);

	// automatic start and stop events
	timer1_evt_gen u_evt_gen (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.tx_end_i(tx_end_i),
		.rx_first_bits_i(rx_first_bits_i),
		.low_freq_oscillator_i(low_freq_oscillator_i),
		.start_mode_field(start_mode_field),
		.stop_on_receive_bit(stop_on_receive_bit),
		.running(running),
		.evt(evt.evt_src)
	);

	// bus decode; a request is taken once, while ack is low
	assign reg_index = wb_adr_i[timer1_pkg::ADR_LSB +: 6];
	assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr_lane0 = bus_req && wb_we_i && wb_sel_i[0];
	assign wr_ctrl1 = wr_lane0 && reg_hit(reg_index, timer1_pkg::IDX_CTRL1);
	assign wr_ctrl2 = wr_lane0 && reg_hit(reg_index, timer1_pkg::IDX_CTRL2);
	assign wr_reload_hi = wr_lane0 && reg_hit(reg_index, timer1_pkg::IDX_RELOAD_HI);
	assign wr_reload_lo = wr_lane0 && reg_hit(reg_index, timer1_pkg::IDX_RELOAD_LO);
	assign wr_start_stop = wr_lane0 && reg_hit(reg_index, timer1_pkg::IDX_START_STOP);
	assign wr_irq_status = wr_lane0 && reg_hit(reg_index, timer1_pkg::IDX_IRQ_STATUS);

	// status write with a one in the flag position clears it
	assign irq_clear = wr_irq_status && wb_dat_i[timer1_pkg::ST_IRQ];

	// a start/stop write moves the running bit only when its enable rides in the same write
	assign cmd_change = wr_start_stop && wb_dat_i[timer1_pkg::SS_ENABLE];
	assign cmd_run = wb_dat_i[timer1_pkg::SS_RUNNING];

	// counting terms
	assign at_zero = (count == timer1_pkg::COUNT_ZERO);
	assign count_step = running && evt.tick;
	// trimming without underflow parks at zero instead of wrapping
	assign trim_hold = (timer1_pkg::start_mode_e'(start_mode_field) == timer1_pkg::START_TRIM_NO_UF);
	assign underflow_now = count_step && at_zero && !trim_hold;

	// next counter and running state; software command wins over events
	always_comb begin
		next_running = running;
		next_count = count;
		if (count_step) begin
			if (!at_zero) begin
				next_count = count - timer1_pkg::COUNT_ONE;
			end else if (trim_hold) begin
				next_running = 1'b0;
			end else if (auto_restart_bit) begin
				next_count = reload_value;
			end else begin
				next_running = 1'b0;
			end
		end
		if (evt.stop_evt) begin
			next_running = 1'b0;
		end
		if (evt.start_evt) begin
			next_running = 1'b1;
			next_count = reload_value;
		end
		if (cmd_change) begin
			next_running = cmd_run;
			if (cmd_run) begin
				next_count = reload_value;
			end
		end
	end

	// counter; reload bytes feed it only on starts and auto-restart underflows
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count <= timer1_pkg::COUNT_ZERO;
		end else begin
			count <= next_count;
		end
	end

	// running status
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			running <= 1'b0;
		end else begin
			running <= next_running;
		end
	end

	// cascade pulse, one cycle per underflow
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			underflow_o <= 1'b0;
		end else begin
			underflow_o <= underflow_now;
		end
	end

	// interrupt flag: write one clears, a same-cycle underflow wins
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			timer_one_irq_flag <= 1'b0;
		end else if (underflow_now) begin
			timer_one_irq_flag <= 1'b1;
		end else if (irq_clear) begin
			timer_one_irq_flag <= 1'b0;
		end
	end

	// timer1 control, reserved bits forced to zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			timer_one_control <= timer1_pkg::CTL_RESET;
		end else if (wr_ctrl1) begin
			timer_one_control <= control_byte(wb_dat_i);
		end
	end

	// timer2 control is only stored here and handed out
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			timer_two_control <= timer1_pkg::CTL_RESET;
		end else if (wr_ctrl2) begin
			timer_two_control <= control_byte(wb_dat_i);
		end
	end

	// reload high byte; a running count never sees it until a start or an auto-restart reload
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			reload_high_byte <= timer1_pkg::BYTE_ZERO;
		end else if (wr_reload_hi) begin
			reload_high_byte <= wb_dat_i[7:0];
		end
	end

	// reload low byte
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			reload_low_byte <= timer1_pkg::BYTE_ZERO;
		end else if (wr_reload_lo) begin
			reload_low_byte <= wb_dat_i[7:0];
		end
	end

	// read mux; unmapped words read zero but are still acknowledged
	always_comb begin
		next_rdata = timer1_pkg::WORD_ZERO;
		unique case (reg_index)
			timer1_pkg::IDX_CTRL1: next_rdata[7:0] = timer_one_control;
			timer1_pkg::IDX_RELOAD_HI: next_rdata[7:0] = reload_high_byte;
			timer1_pkg::IDX_RELOAD_LO: next_rdata[7:0] = reload_low_byte;
			// the two halves are not latched together; read during a stop
			timer1_pkg::IDX_COUNT_HI: next_rdata[7:0] = count[15:8];
			timer1_pkg::IDX_COUNT_LO: next_rdata[7:0] = count[7:0];
			timer1_pkg::IDX_CTRL2: next_rdata[7:0] = timer_two_control;
			timer1_pkg::IDX_START_STOP: next_rdata[timer1_pkg::SS_RUNNING] = running;
			timer1_pkg::IDX_IRQ_STATUS: next_rdata[timer1_pkg::ST_IRQ] = timer_one_irq_flag;
			default: next_rdata = timer1_pkg::WORD_ZERO;
		endcase
	end

	// bus answer one cycle after the request, dropped the cycle after
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= bus_req;
		end
	end

	// read data captured with the request, so it stands beside ack
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= timer1_pkg::WORD_ZERO;
		end else if (bus_req && !wb_we_i) begin
			wb_dat_o <= next_rdata;
		end
	end

	// flag copy for the outside, set in the same cycle as the flag
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			timer_one_irq_flag_o <= 1'b0;
		end else begin
			timer_one_irq_flag_o <= next_irq_view(underflow_now, timer_one_irq_flag);
		end
	end

	// running copy, equal to the running register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			timer_one_running_status_o <= 1'b0;
		end else begin
			timer_one_running_status_o <= next_running;
		end
	end

	// timer2 control copy, one cycle behind the register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			timer_two_control_o <= timer1_pkg::CTL_RESET;
		end else begin
			timer_two_control_o <= timer_two_control;
		end
	end

	// one register index against the decoded bus address
	function automatic logic reg_hit(input logic [5:0] index, input logic [5:0] target);
		reg_hit = (index == target);
	endfunction : reg_hit

	// reserved bits never store, so they read back as zero
	function automatic logic [7:0] control_byte(input logic [31:0] data);
		control_byte = data[7:0] & timer1_pkg::CTL_WRITABLE;
	endfunction : control_byte

	// output copy sets with the flag but clears one cycle after it
	function automatic logic next_irq_view(input logic set_now, input logic flag);
		next_irq_view = flag || set_now;
	endfunction : next_irq_view
endmodule : timer1_countdown

// ### sim/timer1_countdown_chk.sv
`timescale 1ns/1ps
module timer1_countdown_chk (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// frame events and timer outputs
	input wire logic tx_end_i,
	input wire logic rx_first_bits_i,
	input wire logic underflow_o,
	input wire logic timer_one_irq_flag_o,
	input wire logic timer_one_running_status_o,
	input wire logic [7:0] timer_two_control_o
);
	logic [7:0] ctl;
	logic req, take, wr, clr, run;
	// request decode, mirrored from the bus side
	assign req = wb_cyc_i && wb_stb_i;
	assign take = req && !wb_ack_o;
	assign wr = take && wb_we_i && wb_sel_i[0];
	assign clr = wr && wb_adr_i[7:2] == timer1_pkg::IDX_IRQ_STATUS && wb_dat_i[0];
	assign run = timer_one_running_status_o;
	// shadow of timer1 control, needed to judge the mode rules
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctl <= 8'h00;
		end else if (wr && wb_adr_i[7:2] == timer1_pkg::IDX_CTRL1) begin
			ctl <= wb_dat_i[7:0] & 8'hBB;
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_ack_follows: assert property (take |=> wb_ack_o)
		else $error("bus request not answered");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_read_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
		else $error("upper read bits not zero");
	a_t2_mirror: assert property ((wr && wb_adr_i[7:2] == timer1_pkg::IDX_CTRL2)
		|-> ##2 timer_two_control_o == ($past(wb_dat_i, 2) & 32'h0000_00BB))
		else $error("timer2 control copy wrong");
	a_uf_irq: assert property (underflow_o |-> timer_one_irq_flag_o)
		else $error("underflow without flag");
	a_uf_running: assert property (underflow_o |-> $past(run))
		else $error("underflow while stopped");
	a_irq_clear: assert property ($fell(timer_one_irq_flag_o) |-> $past(clr) || $past(clr, 2))
		else $error("flag dropped without clear");
	a_no_auto: assert property ((ctl[5:4] == 2'b00 && !run && tx_end_i && !req) |=> !run)
		else $error("started without command");
	a_tx_start: assert property ((ctl[5:4] == 2'b01 && !run && tx_end_i && !req) |=> run)
		else $error("no start at end of transmission");
	a_rx_stop: assert property ((ctl[7] && !ctl[5] && run && rx_first_bits_i && !tx_end_i && !req)
		|=> !run)
		else $error("receive did not stop timer");
	// main scenarios seen at least once
	c_underflow: cover property (underflow_o);
	c_start: cover property ($rose(run));
	c_clear: cover property (clr);
endmodule : timer1_countdown_chk

// ### sim/reader_timer1_countdown_tb.sv
`timescale 1ns/1ps
module reader_timer1_countdown_tb;
	logic clk_i, rst_i, cyc, stb, we, ack, uf, irq, run;
	logic [7:0] adr, t2c, q, d;
	logic [3:0] sel;
	logic [31:0] dat, rdat, x;
	logic [5:0] pin; // rf, t0, t2, tx end, rx, lfo
	int num_errors, n_checks, n_uf, r, s;
	int src[4] = '{0, 0, 1, 2};
	// per entry: control, event pin, pulses, expected running
	logic [31:0] ev[9] = '{32'h0003_0100, 32'h1003_0101, 32'h1004_0101, 32'h9004_0100, 32'hB005_0101,
		32'hB004_0101, 32'hB005_0100, 32'hA005_0101, 32'hA000_0300};

	timer1_countdown u_dut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .rf_tick_i(pin[0]),
		.t0_underflow_i(pin[1]), .t2_underflow_i(pin[2]), .tx_end_i(pin[3]), .rx_first_bits_i(pin[4]),
		.low_freq_oscillator_i(pin[5]), .underflow_o(uf), .timer_one_irq_flag_o(irq),
		.timer_one_running_status_o(run), .timer_two_control_o(t2c));

	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	// underflow pulses counted for later comparison
	always @(posedge clk_i) if (uf === 1'b1) n_uf++;

	function automatic logic [31:0] rnd();
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction : rnd
	// control bytes keep writable bits only, counts ignore writes
	function automatic logic [7:0] exp_reg(input logic [5:0] i, input logic [7:0] v);
		if (i == timer1_pkg::IDX_CTRL1 || i == timer1_pkg::IDX_CTRL2) return v & 8'hBB;
		if (i == timer1_pkg::IDX_COUNT_HI || i == timer1_pkg::IDX_COUNT_LO) return 8'h00;
		return v;
	endfunction : exp_reg

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// one classic cycle; only the watchdog ends a wait for ack
	task automatic wb(input logic w, input logic [5:0] i, input logic [7:0] v);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {i, 2'b00};
		dat <= {24'h00_0000, v};
		do begin
			@(posedge clk_i);
		end while (ack !== 1'b1);
		q = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb
	// one-cycle pulses with a gap, then time for outputs to settle
	task automatic pulse(input int b, input int k);
		repeat (k) begin
			@(posedge clk_i);
			pin[b] <= 1'b1;
			@(posedge clk_i);
			pin[b] <= 1'b0;
		end
		repeat (3) @(posedge clk_i);
		#1;
	endtask : pulse
	task automatic done(input string t);
		$display("test %s finished, errors %0d", t, num_errors);
	endtask : done
	task automatic close_out();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : close_out

	// a hang is cut short well beyond the expected run
	initial begin
		#2_000_000;
		num_errors++;
		close_out();
	end

	initial begin
		rst_i = 1'b1;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		sel = 4'h1;
		dat = 32'h0000_0000;
		pin = 6'h00;
		x = 32'h0000_0012;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		for (logic [5:0] i = 6'h14; i <= 6'h19; i++) begin
			wb(1'b0, i, 8'h00);
			chk(q, 8'h00);
			d = 8'(rnd());
			wb(1'b1, i, d);
			wb(1'b0, i, 8'h00);
			chk(q, exp_reg(i, d));
		end
		chk(t2c, exp_reg(6'h19, d));
		wb(1'b1, 6'h14, 8'h00);
		wb(1'b0, 6'h20, 8'h00);
		chk(q, 8'h00);
		done("registers");
		r = int'(rnd() % 6) + 1;
		wb(1'b1, 6'h15, 8'h00);
		wb(1'b1, 6'h16, 8'(r));
		wb(1'b1, 6'h1E, 8'h22);
		chk({7'h00, run}, 8'h01);
		wb(1'b1, 6'h16, 8'(r + 7));
		pulse(0, 1);
		wb(1'b1, 6'h1E, 8'h02);
		wb(1'b0, 6'h18, 8'h00);
		chk(q, 8'(r - 1));
		wb(1'b1, 6'h1E, 8'h22);
		wb(1'b0, 6'h18, 8'h00);
		chk(q, 8'(r + 7));
		wb(1'b1, 6'h1E, 8'h00);
		pulse(0, r + 7);
		chk({6'h00, run, irq}, 8'h02);
		s = n_uf;
		pulse(0, 1);
		chk({6'h00, run, irq}, 8'h01);
		chk(8'(n_uf - s), 8'h01);
		wb(1'b1, 6'h1F, 8'h01);
		wb(1'b0, 6'h1F, 8'h00);
		chk(q, 8'h00);
		done("count");
		wb(1'b1, 6'h14, 8'h08);
		wb(1'b1, 6'h16, 8'(r));
		wb(1'b1, 6'h1E, 8'h22);
		s = n_uf;
		pulse(0, r + 2);
		wb(1'b1, 6'h1E, 8'h02);
		chk(8'(n_uf - s), 8'h01);
		wb(1'b0, 6'h18, 8'h00);
		chk(q, 8'(r - 1));
		done("restart");
		wb(1'b1, 6'h16, 8'h00);
		for (s = 0; s < 4; s++) begin
			wb(1'b1, 6'h14, 8'(s));
			wb(1'b1, 6'h1E, 8'h22);
			r = n_uf;
			for (int b = 0; b < 3; b++) if (b != src[s]) pulse(b, 1);
			chk(8'(n_uf - r), 8'h00);
			pulse(src[s], s == 1 ? 64 : 1);
			chk(8'(n_uf - r), 8'h01);
		end
		done("clock");
		wb(1'b1, 6'h16, 8'h02);
		r = n_uf;
		for (s = 0; s < 9; s++) begin
			wb(1'b1, 6'h14, ev[s][31:24]);
			pulse(ev[s][23:16], ev[s][15:8]);
			chk({7'h00, run}, ev[s][7:0]);
		end
		chk(8'(n_uf - r), 8'h00);
		done("modes");
		close_out();
	end
endmodule : reader_timer1_countdown_tb

bind timer1_countdown timer1_countdown_chk u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
	.wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .tx_end_i, .rx_first_bits_i, .underflow_o,
	.timer_one_irq_flag_o, .timer_one_running_status_o, .timer_two_control_o);
